// ==== pes_pkg.sv ====
// Purpose: Shared constants for the port 2 EEE status register bank.
// Assumes: Avalon-MM byte addressing with 32-bit data, one word per register.
// Notes: Byte address of a register is four times its index.
package pes_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam logic [7:0] IDX_ADV = 8'hec;
    localparam logic [7:0] IDX_WEC = 8'hee;
    localparam logic [7:0] IDX_STAT = 8'hf0;
    localparam int CLK_PERIOD_NS = 20;
    localparam real WAKE_LIMIT_US = 20.5;
    localparam int WAKE_LIMIT_CYC = int'(WAKE_LIMIT_US * 1000.0 / CLK_PERIOD_NS);
    localparam int ADV_100TX_BIT = 1;
    localparam logic ADV_100TX_RST = 1'b1;
    localparam int LP_EEE_W = 6;
    localparam int LOC_RO_W = 5;
    localparam logic [LOC_RO_W-1:0] LOC_RO_VAL = 5'h00;
    localparam logic [15:0] WEC_RST = 16'h0000;
    localparam logic [15:0] WEC_MAX = 16'hffff;
    localparam logic [15:0] WEC_ONE = 16'h0001;
    localparam int STAT_TX_LAT_BIT = 13;
    localparam int STAT_RX_LAT_BIT = 11;
    localparam logic STAT_RSV15_RST = 1'b1;
    localparam logic [1:0] STAT_RSV98_RST = 2'h0;
    localparam logic NP_LOC_ABLE_VAL = 1'b1;
    localparam logic NP_LOC_VAL = 1'b1;
    localparam int SYNC_W = 13;
endpackage

// ==== pes_sync.sv ====
// Purpose: Two-stage synchroniser for a bus of independent level inputs.
// Assumes: Each bit is a slow level; bits are not coherent with each other.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module pes_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule

// ==== pes_sticky.sv ====
// Purpose: Latching-high status flag with set priority over clear.
// Assumes: Set and clear come from logic on sys_clk.
// Notes: A set in the clearing cycle keeps the flag high so no event is lost.
`timescale 1ns/1ps
module pes_sticky (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    logic flag_ff;
    logic nxt_flag;

    assign nxt_flag = set | (flag_ff & ~clr);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign q = flag_ff;
endmodule

// ==== pes_regs.sv ====
// Purpose: Port 2 EEE advertisement, wake error count and status register bank.
// Assumes: Line-side status arrives asynchronously and is synchronised here.
// Notes: Reads take two cycles; writes complete in the cycle they are presented.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
module pes_regs
    import pes_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [pes_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [pes_pkg::BE_W-1:0] avs_byteenable,
    input wire logic [pes_pkg::DATA_W-1:0] avs_writedata,
    output logic [pes_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic wake_timer_done,
    input wire logic tx_lpi_active,
    input wire logic rx_lpi_active,
    input wire logic hw_eee_enabled,
    input wire logic [pes_pkg::LP_EEE_W-1:0] partner_eee_ability,
    input wire logic parallel_fault,
    input wire logic partner_np_able,
    input wire logic fiber_mode,
    output logic eee_adv_100tx
);
    import pes_pkg::*;

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic wake_s;
    logic tx_lpi_s;
    logic rx_lpi_s;
    logic hw_en_s;
    logic [LP_EEE_W-1:0] lp_eee_s;
    logic pd_fault_s;
    logic lp_np_s;
    logic fiber_s;

    assign sync_in = {fiber_mode, partner_np_able, parallel_fault, partner_eee_ability,
                      hw_eee_enabled, rx_lpi_active, tx_lpi_active, wake_timer_done};

    pes_sync #(.W(SYNC_W)) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .d(sync_in),
        .q(sync_out)
    );

    assign wake_s = sync_out[0];
    assign tx_lpi_s = sync_out[1];
    assign rx_lpi_s = sync_out[2];
    assign hw_en_s = sync_out[3];
    assign lp_eee_s = sync_out[9:4];
    assign pd_fault_s = sync_out[10];
    assign lp_np_s = sync_out[11];
    assign fiber_s = sync_out[12];

    // Bus decode. The read value is captured one cycle before it is handed over.
    logic rd_pend_ff;
    logic nxt_rd_pend;
    logic rd_capture;
    logic [7:0] reg_idx;
    logic sel_adv;
    logic sel_wec;
    logic sel_stat;
    logic wr_adv;
    logic wr_stat_hi;

    assign reg_idx = avs_address[ADDR_W-1:2];
    assign sel_adv = (reg_idx == IDX_ADV);
    assign sel_wec = (reg_idx == IDX_WEC);
    assign sel_stat = (reg_idx == IDX_STAT);
    assign rd_capture = avs_read & ~rd_pend_ff;
    assign nxt_rd_pend = rd_capture;
    assign avs_waitrequest = avs_read & ~rd_pend_ff;
    assign wr_adv = avs_write & sel_adv & avs_byteenable[0];
    assign wr_stat_hi = avs_write & sel_stat & avs_byteenable[1];

    // Fiber mode suppresses the LPI, hardware-enable and wake indications and the advertisement pin; adv_ff and partner ability still read back.
    logic eee_ok;
    logic tx_live;
    logic rx_live;
    logic hw_en_eff;

    assign eee_ok = ~fiber_s;
    assign tx_live = tx_lpi_s & eee_ok;
    assign rx_live = rx_lpi_s & eee_ok;
    assign hw_en_eff = hw_en_s & eee_ok;

    // Advertisement register.
    logic adv_ff;
    logic nxt_adv;

    // Clearing this bit alone does not stop EEE negotiation; the next-page enable does.
    assign nxt_adv = wr_adv ? avs_writedata[ADV_100TX_BIT] : adv_ff;
    assign eee_adv_100tx = adv_ff & eee_ok;

    // Wake error counter.
    logic [15:0] wec_ff;
    logic [15:0] nxt_wec;
    logic wake_d_ff;
    logic wake_rise;
    logic wec_clr;
    logic wec_sat;

    assign wake_rise = wake_s & ~wake_d_ff & eee_ok;
    assign wec_clr = rd_capture & sel_wec;
    assign wec_sat = (wec_ff == WEC_MAX);
    assign nxt_wec = wec_clr ? (wake_rise ? WEC_ONE : WEC_RST) :
                     (wake_rise & ~wec_sat) ? wec_ff + WEC_ONE : wec_ff;

    // Latched flags.
    logic tx_lat;
    logic rx_lat;
    logic pd_lat;
    logic tx_clr;
    logic rx_clr;
    logic pd_clr;

    assign tx_clr = wr_stat_hi & avs_writedata[STAT_TX_LAT_BIT];
    assign rx_clr = wr_stat_hi & avs_writedata[STAT_RX_LAT_BIT];
    assign pd_clr = rd_capture & sel_stat;

    pes_sticky u_tx_lat (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .set(tx_live),
        .clr(tx_clr),
        .q(tx_lat)
    );

    pes_sticky u_rx_lat (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .set(rx_live),
        .clr(rx_clr),
        .q(rx_lat)
    );

    pes_sticky u_pd_lat (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .set(pd_fault_s),
        .clr(pd_clr),
        .q(pd_lat)
    );

    // Reserved status bits are kept as plain storage so software reads back its write.
    logic rsv15_ff;
    logic nxt_rsv15;
    logic [1:0] rsv98_ff;
    logic [1:0] nxt_rsv98;

    assign nxt_rsv15 = wr_stat_hi ? avs_writedata[15] : rsv15_ff;
    assign nxt_rsv98 = wr_stat_hi ? avs_writedata[9:8] : rsv98_ff;

    // Read words.
    logic [15:0] adv_word;
    logic [15:0] stat_word;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;

    assign adv_word = {1'b0, lp_eee_s, 2'b00, LOC_RO_VAL, adv_ff, 1'b0};
    assign stat_word = {rsv15_ff, hw_en_eff, tx_lat, tx_live, rx_lat, rx_live,
                        rsv98_ff, 1'b0, NP_LOC_ABLE_VAL, NP_LOC_VAL,
                        pd_lat, lp_np_s, 3'b000};
    assign rd_word = sel_adv ? {16'h0000, adv_word} :
                     sel_wec ? {16'h0000, wec_ff} :
                     sel_stat ? {16'h0000, stat_word} : '0;
    assign nxt_rdata = rd_capture ? rd_word : rdata_ff;
    assign avs_readdata = rdata_ff;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_pend_ff <= 1'b0;
            rdata_ff <= '0;
        end else begin
            rd_pend_ff <= nxt_rd_pend;
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            adv_ff <= ADV_100TX_RST;
            wec_ff <= WEC_RST;
            wake_d_ff <= 1'b0;
        end else begin
            adv_ff <= nxt_adv;
            wec_ff <= nxt_wec;
            wake_d_ff <= wake_s;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rsv15_ff <= STAT_RSV15_RST;
            rsv98_ff <= STAT_RSV98_RST;
        end else begin
            rsv15_ff <= nxt_rsv15;
            rsv98_ff <= nxt_rsv98;
        end
    end

    // Checks.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    property p_wake_inc;
        wake_rise && !wec_clr && !wec_sat |=> wec_ff == $past(wec_ff) + WEC_ONE;
    endproperty
    a_wake_inc: assert property (p_wake_inc)
        else $error("Wake error count did not step on a wake edge.");

    property p_wake_sat;
        wec_sat && !wec_clr |=> wec_sat;
    endproperty
    a_wake_sat: assert property (p_wake_sat)
        else $error("Wake error count left all ones without a read.");

    property p_wec_read;
        wec_clr |=> (avs_readdata[15:0] == $past(wec_ff)) &&
            (wec_ff == {15'h0000, $past(wake_rise)});
    endproperty
    a_wec_read: assert property (p_wec_read)
        else $error("Wake error count read did not return and clear the count.");

    property p_wec_race;
        wec_clr && wake_rise |=> wec_ff == WEC_ONE;
    endproperty
    a_wec_race: assert property (p_wec_race)
        else $error("Wake edge during clearing read was lost.");

    property p_tx_latch;
        tx_live |=> tx_lat;
    endproperty
    a_tx_latch: assert property (p_tx_latch)
        else $error("Transmit LPI flag failed to latch.");

    property p_rx_hold;
        rx_lat && !rx_clr |=> rx_lat;
    endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("Receive LPI flag dropped without a clear.");

    property p_rx_latch;
        rx_live |=> rx_lat;
    endproperty
    a_rx_latch: assert property (p_rx_latch)
        else $error("Receive LPI flag failed to latch.");

    property p_rx_clear;
        rx_clr && !rx_live |=> !rx_lat;
    endproperty
    a_rx_clear: assert property (p_rx_clear)
        else $error("Receive LPI flag not cleared by writing one.");

    property p_tx_clear;
        tx_clr && !tx_live |=> !tx_lat;
    endproperty
    a_tx_clear: assert property (p_tx_clear)
        else $error("Transmit LPI flag not cleared by writing one.");

    property p_live_read;
        rd_capture && sel_stat |=> avs_readdata[12] == $past(tx_live) &&
            avs_readdata[10] == $past(rx_live);
    endproperty
    a_live_read: assert property (p_live_read)
        else $error("Live LPI bits read back wrong.");

    property p_adv_write;
        wr_adv |=> adv_ff == $past(avs_writedata[ADV_100TX_BIT]) ##1
            adv_ff == $past(adv_ff) || $past(wr_adv);
    endproperty
    a_adv_write: assert property (p_adv_write)
        else $error("Advertisement bit did not take the write.");

    property p_adv_ro;
        rd_capture && sel_adv |=> avs_readdata[6:2] == LOC_RO_VAL &&
            avs_readdata[14:9] == $past(lp_eee_s);
    endproperty
    a_adv_ro: assert property (p_adv_ro)
        else $error("Advertisement read-only fields read wrong.");

    property p_pd_clear;
        pd_clr && !pd_fault_s |=> !pd_lat;
    endproperty
    a_pd_clear: assert property (p_pd_clear)
        else $error("Parallel fault flag not cleared by status read.");

    property p_pd_latch;
        pd_fault_s |=> pd_lat;
    endproperty
    a_pd_latch: assert property (p_pd_latch)
        else $error("Parallel fault flag failed to latch.");

    property p_stat_read;
        rd_capture && sel_stat |=> avs_readdata[14] == $past(hw_en_eff) &&
            avs_readdata[6:3] == {NP_LOC_ABLE_VAL, NP_LOC_VAL, $past(pd_lat), $past(lp_np_s)};
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("Status read returned wrong expansion bits.");

    property p_fiber;
        fiber_s |-> !tx_live && !rx_live && !hw_en_eff && !eee_adv_100tx && !wake_rise;
    endproperty
    a_fiber: assert property (p_fiber)
        else $error("EEE activity seen in fiber mode.");

    property p_read_wait;
        avs_read && !rd_pend_ff |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("Read answer timing broken.");

    c_wec_clear: cover property (wec_clr && wec_ff != WEC_RST);
    c_wec_sat: cover property (wec_sat && wake_rise);
    c_tx_clear: cover property (tx_lat && tx_clr);
    c_pd_clear: cover property (pd_lat && pd_clr);
    c_wec_race: cover property (wec_clr && wake_rise);
endmodule

// ==== pes_partner.sv ====
// Purpose: Line-side model of the copper link partner and local PCS status lines.
// Assumes: Every output is a slow level sampled through synchronisers in the block.
// Notes: Each change is held six cycles so that a two-flop synchroniser sees it.
`timescale 1ns/1ps
module pes_partner (
    input wire logic sys_clk,
    output logic wake_timer_done,
    output logic tx_lpi_active,
    output logic rx_lpi_active,
    output logic hw_eee_enabled,
    output logic [5:0] partner_eee_ability,
    output logic parallel_fault,
    output logic partner_np_able,
    output logic fiber_mode
);
    // Line order: fiber, next-page able, fault, ability[5:0], hw enable, rx, tx, wake.
    logic [12:0] line_ff = 13'h0000;

    assign {fiber_mode, partner_np_able, parallel_fault, partner_eee_ability,
            hw_eee_enabled, rx_lpi_active, tx_lpi_active, wake_timer_done} = line_ff;

    // All lines move together just after an edge, then stand for six cycles.
    task automatic drive(input logic [12:0] v);
        @(posedge sys_clk);
        line_ff <= v;
        repeat (6) @(posedge sys_clk);
    endtask

    // Order of v is fiber, next-page able, hw enable, rx LPI, tx LPI.
    task automatic set_lines(input logic [4:0] v);
        drive({v[4], v[3], line_ff[10:4], v[2:0], line_ff[0]});
    endtask

    // Each pulse is one rising transition, so one wake error apiece.
    task automatic wake(input int n);
        repeat (n) begin
            drive({line_ff[12:1], 1'b1});
            drive({line_ff[12:1], 1'b0});
        end
    endtask

    task automatic pd_pulse();
        drive({line_ff[12:11], 1'b1, line_ff[9:0]});
        drive({line_ff[12:11], 1'b0, line_ff[9:0]});
    endtask

    task automatic set_ability(input logic [5:0] a);
        drive({line_ff[12:10], a, line_ff[3:0]});
    endtask
endmodule

// ==== port2_eee_status_regs_bench.sv ====
// Purpose: Self-checking bench for the port 2 EEE register bank.
// Assumes: Avalon-MM master that waits for waitrequest low on every access.
// Notes: Saturation needs 65535 wake events, too long here; the block's own check covers it.
`timescale 1ns/1ps
module port2_eee_status_regs_bench;
    import pes_pkg::*;
    localparam logic [9:0] A_ADV = {IDX_ADV, 2'h0};
    localparam logic [9:0] A_WEC = {IDX_WEC, 2'h0};
    localparam logic [9:0] A_STAT = {IDX_STAT, 2'h0};
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic wake_timer_done;
    logic tx_lpi_active;
    logic rx_lpi_active;
    logic hw_eee_enabled;
    logic parallel_fault;
    logic partner_np_able;
    logic fiber_mode;
    logic eee_adv_100tx;
    logic [5:0] partner_eee_ability;
    int error_cnt = 0;
    int n_compared = 0;

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    pes_regs pes_regs_inst (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .wake_timer_done(wake_timer_done),
        .tx_lpi_active(tx_lpi_active), .rx_lpi_active(rx_lpi_active),
        .hw_eee_enabled(hw_eee_enabled), .partner_eee_ability(partner_eee_ability),
        .parallel_fault(parallel_fault), .partner_np_able(partner_np_able),
        .fiber_mode(fiber_mode), .eee_adv_100tx(eee_adv_100tx));

    pes_partner pes_partner_inst (.sys_clk(sys_clk), .wake_timer_done(wake_timer_done),
        .tx_lpi_active(tx_lpi_active), .rx_lpi_active(rx_lpi_active),
        .hw_eee_enabled(hw_eee_enabled), .partner_eee_ability(partner_eee_ability),
        .parallel_fault(parallel_fault), .partner_np_able(partner_np_able),
        .fiber_mode(fiber_mode));

    task automatic give_verdict();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // The request is held until the edge at which waitrequest is seen low.
    task automatic bus(input logic rd, input logic [9:0] a, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= rd;
        avs_write <= ~rd;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            $display("[FAIL] waitrequest expected 0 seen %b", avs_waitrequest);
            give_verdict();
        end
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b0, a, wd, 4'hf, d);
    endtask

    task automatic wr_be(input logic [9:0] a, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] d;
        bus(1'b0, a, wd, be, d);
    endtask

    task automatic chk(input string nm, input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b1, a, 32'h0, 4'hf, d);
        cmp(nm, exp, d);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        give_verdict();
    end

    initial begin
        int live;
        int lat;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        chk("adv reset", A_ADV, 32'h0000_0002);
        chk("wec reset", A_WEC, 32'h0000_0000);
        chk("stat reset", A_STAT, 32'h0000_8060);
        cmp("adv pin", 32'h1, {31'h0, eee_adv_100tx});
        wr(A_ADV, 32'hffff_ffff);
        chk("adv ro bits", A_ADV, 32'h0000_0002);
        wr_be(A_ADV, 32'h0000_0000, 4'he);
        chk("adv lane0 off", A_ADV, 32'h0000_0002);
        wr(A_ADV, 32'h0000_0000);
        chk("adv cleared", A_ADV, 32'h0000_0000);
        cmp("adv pin off", 32'h0, {31'h0, eee_adv_100tx});
        wr(A_ADV, 32'h0000_0002);
        pes_partner_inst.set_ability(6'h2a);
        chk("partner ability", A_ADV, 32'h0000_5402);
        pes_partner_inst.wake(3);
        wr(A_WEC, 32'h0000_1234);
        chk("wake count", A_WEC, 32'h0000_0003);
        chk("wake cleared", A_WEC, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            live = (i == 0) ? 32'h1000 : 32'h0400;
            lat = (i == 0) ? 32'h2000 : 32'h0800;
            pes_partner_inst.set_lines((i == 0) ? 5'h01 : 5'h02);
            chk("lpi live", A_STAT, 32'h8060 | live | lat);
            pes_partner_inst.set_lines(5'h00);
            chk("lpi latched", A_STAT, 32'h8060 | lat);
            chk("lpi held", A_STAT, 32'h8060 | lat);
            wr_be(A_STAT, 32'h8000 | lat, 4'h1);
            chk("lpi lane1 off", A_STAT, 32'h8060 | lat);
            wr(A_STAT, 32'h8000 | lat);
            chk("lpi w1c", A_STAT, 32'h0000_8060);
        end
        pes_partner_inst.set_lines(5'h0c);
        chk("hw en np able", A_STAT, 32'h0000_c068);
        wr(A_ADV, 32'h0000_0000);
        chk("hw en adv off", A_STAT, 32'h0000_c068);
        pes_partner_inst.set_lines(5'h00);
        wr(A_ADV, 32'h0000_0002);
        pes_partner_inst.pd_pulse();
        chk("pd fault", A_STAT, 32'h0000_8070);
        chk("pd cleared", A_STAT, 32'h0000_8060);
        pes_partner_inst.set_lines(5'h17);
        pes_partner_inst.wake(1);
        cmp("fiber adv pin", 32'h0, {31'h0, eee_adv_100tx});
        chk("fiber stat", A_STAT, 32'h0000_8060);
        chk("fiber wec", A_WEC, 32'h0000_0000);
        chk("fiber adv", A_ADV, 32'h0000_5402);
        pes_partner_inst.set_lines(5'h10);
        pes_partner_inst.set_lines(5'h00);
        cmp("copper adv pin", 32'h1, {31'h0, eee_adv_100tx});
        wr(10'h000, 32'hffff_ffff);
        chk("unmapped", 10'h000, 32'h0000_0000);
        give_verdict();
    end
endmodule
